/* File: rtl/shift_rotate_cfg.svh */
`ifndef SHIFT_ROTATE_CFG_SVH
`define SHIFT_ROTATE_CFG_SVH

// ****************************************
// Instruction word layout
// ****************************************
`define OPCODE_HI 29
`define OPCODE_LO 25
`define OPCODE_SHIFT 5'h0E
`define INDEX_HI 24
`define INDEX_LO 22
`define ADDR_HI 20
`define ADDR_LO 6
`define CIRC_BIT 5
`define COUNT_CODE_HI 4
`define COUNT_CODE_LO 3
`define SHIFT_HI 2
`define SHIFT_LO 0
`define CHAR_BITS 8'h06
`define SHIFT_MAX 8'h07

// ****************************************
// Timing, in half units of the time unit
// ****************************************
`define BASE_HALF_UNITS 8'h51
`define PER_BIT_HALF_UNITS 8'h12
`define PER_CODE_HALF_UNITS 8'h24
// One half unit of time per clock cycle
`define CYCLES_PER_HALF_UNIT 16'h0001
// Count left when leaving busy: the write cycle still follows
`define WAIT_LAST 16'h0003

`endif

/* File: rtl/shift_rotate_pkg.sv */
package shift_rotate_pkg;
  typedef enum logic [1:0] {st_idle, st_read, st_busy, st_write} sr_state_t;
endpackage

/* File: rtl/character_shift_rotate_unit.sv */
// Function
// - Rotate moves 1-4 chars left by count
// - Working width 6, 12, 18 or 24 bits
// - Rotated-out bits re-enter at low end
// - Result written back to same field
// - Time 40.5 + S(9 + 18n) units
// - Bit5 clear is plain shift, same fields
// - Plain shift drops high bits, zero fill
// - Shift count at most seven
`timescale 1ns/1ps
`default_nettype none
`include "shift_rotate_cfg.svh"

module character_shift_rotate_unit
  import shift_rotate_pkg::*;
#(
  parameter int ADDR_W = 15,
  parameter int DATA_W = 24
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic [29:0] i_instr,
  output logic o_index_sel_valid,
  output logic [2:0] o_index_sel,
  input wire logic [ADDR_W-1:0] i_index_value,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic [1:0] o_mem_count_code,
  input wire logic [DATA_W-1:0] i_mem_rdata,
  output logic [DATA_W-1:0] o_mem_wdata,
  output logic o_busy,
  output logic o_done,
  output logic o_illegal
);

  // ****************************************
  // Check timing
  // ****************************************
  default clocking check_edge @(posedge i_clock);
  endclocking
  default disable iff (i_reset);

  // ****************************************
  // Decode
  // ****************************************
  logic is_shift;
  assign is_shift = i_instr[`OPCODE_HI:`OPCODE_LO] == `OPCODE_SHIFT;
  assign o_index_sel = i_instr[`INDEX_HI:`INDEX_LO];
  assign o_index_sel_valid = i_start && is_shift &&
    (i_instr[`INDEX_HI:`INDEX_LO] != 3'h0);

  // Width mask for 6, 12, 18 or 24 bits
  function automatic logic [DATA_W-1:0] width_mask(input logic [1:0] code);
    width_mask = DATA_W'((32'h1 << (`CHAR_BITS * (32'(code) + 32'h1))) -
      32'h1);
  endfunction

  // ****************************************
  // State
  // ****************************************
  sr_state_t state_r;
  logic circ_r;
  logic [1:0] code_r;
  logic [2:0] count_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] data_r;
  logic [15:0] wait_r;

  // Total cycles: (81 + S*(18 + 36n)) half units
  function automatic logic [15:0] exec_cycles(input logic [2:0] s,
      input logic [1:0] n);
    logic [15:0] per;
    per = 16'(`PER_BIT_HALF_UNITS) + 16'(`PER_CODE_HALF_UNITS) * 16'(n);
    exec_cycles = (16'(`BASE_HALF_UNITS) + 16'(s) * per) *
      `CYCLES_PER_HALF_UNIT;
  endfunction

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_r <= st_idle;
    end else begin
      case (state_r)
        st_idle: begin
          if (i_start && is_shift) begin
            state_r <= st_read;
          end
        end
        st_read: state_r <= st_busy;
        st_busy: begin
          if (wait_r == `WAIT_LAST) begin
            state_r <= st_write;
          end
        end
        st_write: state_r <= st_idle;
        default: state_r <= st_idle;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      circ_r <= 1'b0;
      code_r <= 2'h0;
      count_r <= 3'h0;
      addr_r <= '0;
    end else if (state_r == st_idle && i_start && is_shift) begin
      circ_r <= i_instr[`CIRC_BIT];
      code_r <= i_instr[`COUNT_CODE_HI:`COUNT_CODE_LO];
      count_r <= i_instr[`SHIFT_HI:`SHIFT_LO];
      // Points at the least significant character
      addr_r <= (i_instr[`INDEX_HI:`INDEX_LO] != 3'h0) ?
        ADDR_W'(i_instr[`ADDR_HI:`ADDR_LO] + i_index_value) :
        i_instr[`ADDR_HI:`ADDR_LO];
    end
  end

  // Count runs the whole instruction time, start cycle included
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      wait_r <= 16'h0;
    end else if (state_r == st_idle && i_start && is_shift) begin
      wait_r <= exec_cycles(i_instr[`SHIFT_HI:`SHIFT_LO],
        i_instr[`COUNT_CODE_HI:`COUNT_CODE_LO]);
    end else if (wait_r != 16'h0) begin
      wait_r <= wait_r - 16'h1;
    end
  end

  // ****************************************
  // Datapath
  // ****************************************
  // Moves one bit per step, as the register itself would, so a count
  // above the six-bit width needs no special case
  function automatic logic [DATA_W-1:0] shift_field(
      input logic [DATA_W-1:0] d,
      input logic [1:0] code,
      input logic [2:0] s,
      input logic circ);
    logic [DATA_W-1:0] m;
    logic [DATA_W-1:0] v;
    logic top;
    m = width_mask(code);
    v = d & m;
    top = 1'b0;
    for (int i = 0; i < int'(`SHIFT_MAX); i++) begin
      if (i < int'(s)) begin
        top = |(v & m & ~(m >> 1));
        v = ((v << 1) & m) | (circ ? DATA_W'(top) : '0);
      end
    end
    shift_field = v;
  endfunction

  logic [DATA_W-1:0] mask;
  logic [DATA_W-1:0] field_in;
  logic [DATA_W-1:0] result;
  logic [4:0] field_bits;
  logic [4:0] rot_amt;
  always_comb begin
    mask = width_mask(code_r);
    field_in = i_mem_rdata & mask;
    result = shift_field(i_mem_rdata, code_r, count_r, circ_r);
    // Closed form for the checks; counts stay under twice the width
    field_bits = 5'(`CHAR_BITS * (32'(code_r) + 32'h1));
    rot_amt = (5'(count_r) >= field_bits) ? 5'(count_r) - field_bits :
      5'(count_r);
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      data_r <= '0;
    end else if (state_r == st_read) begin
      data_r <= result;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_mem_rd = state_r == st_read;
  assign o_mem_wr = state_r == st_write;
  assign o_mem_addr = addr_r;
  assign o_mem_count_code = code_r;
  assign o_mem_wdata = data_r;
  assign o_busy = state_r != st_idle;
  assign o_done = state_r == st_write;
  assign o_illegal = i_start && !is_shift;

  // ****************************************
  // Checks
  // ****************************************
  wrap_low_a: assert property (circ_r && state_r == st_busy &&
    $past(state_r) == st_read |->
    data_r == (mask & (($past(field_in) << rot_amt) |
    ($past(field_in) >> (field_bits - rot_amt)))))
    else $error("rotate did not wrap");
  plain_shift_a: assert property (!circ_r && state_r == st_busy &&
    $past(state_r) == st_read |->
    data_r == (mask & ($past(field_in) << count_r)))
    else $error("plain shift value wrong");
  zero_fill_a: assert property (!circ_r && state_r == st_busy |->
    (data_r & ~mask) == '0 &&
    (data_r & DATA_W'((32'h1 << count_r) - 32'h1)) == '0)
    else $error("shift fill not zero");
  field_width_a: assert property (o_mem_wr |->
    (o_mem_wdata >> field_bits) == '0)
    else $error("write data wider than field");

  // Read follows the start cycle, the write takes the last cycle
  localparam int WB_FIRST = int'(`BASE_HALF_UNITS) *
    int'(`CYCLES_PER_HALF_UNIT) - 32'h2;
  localparam int WB_LAST = (int'(`BASE_HALF_UNITS) + int'(`SHIFT_MAX) *
    (int'(`PER_BIT_HALF_UNITS) + 32'h3 * int'(`PER_CODE_HALF_UNITS))) *
    int'(`CYCLES_PER_HALF_UNIT) - 32'h2;
  write_back_a: assert property (o_mem_rd |-> ##[WB_FIRST:WB_LAST]
    o_mem_wr && o_mem_addr == $past(o_mem_addr))
    else $error("no write back");
  exec_time_a: assert property (state_r == st_idle && i_start &&
    is_shift && i_instr[`SHIFT_HI:`SHIFT_LO] == 3'h0 |-> ##80 o_done)
    else $error("base time wrong");
  addr_index_a: assert property (state_r == st_idle && i_start &&
    is_shift && i_instr[`INDEX_HI:`INDEX_LO] != 3'h0 |=>
    o_mem_addr == ADDR_W'($past(i_instr[`ADDR_HI:`ADDR_LO]) +
    $past(i_index_value)))
    else $error("indexed address wrong");

endmodule

`default_nettype wire

/* File: test/char_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Character memory
// ****
module char_mem_model (
  input wire logic i_clock,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [14:0] i_addr,
  input wire logic [1:0] i_code,
  input wire logic [23:0] i_wdata,
  output logic [23:0] o_rdata
);
  logic [5:0] mem [0:63];
  logic [23:0] fld;
  always_comb begin
    fld = 24'hFFFFFF;
    for (int k = 0; k <= i_code; k++) begin
      fld[6*k+:6] = mem[i_addr[5:0]-6'(k)];
    end
    // Stale data inverted off the read cycle
    o_rdata = i_rd ? fld : ~fld;
  end
  // Plain always so that the bench may preload the array
  always @(posedge i_clock) begin
    if (i_wr) begin
      for (int k = 0; k <= i_code; k++) begin
        mem[i_addr[5:0]-6'(k)] <= i_wdata[6*k+:6];
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench
// ****
module testbench;
  typedef struct {logic r; logic [1:0] n; logic [2:0] s; logic [2:0] x;
    logic [23:0] d; logic [23:0] e;} row_t;
  logic i_clock = 0;
  logic i_reset = 1;
  logic i_start = 0;
  logic [29:0] i_instr = '0;
  logic [14:0] i_index_value = '0;
  logic [14:0] addr;
  logic [14:0] maddr;
  logic [23:0] rdata;
  logic [23:0] wdata;
  logic [1:0] code;
  logic rd, wr, busy, done, illegal;
  logic sel_v;
  logic [2:0] sel;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  row_t rows [6] = '{
    '{0, 1, 3, 0, 24'hD4F, 24'hA78},
    '{1, 2, 5, 3, 24'h26D4F, 24'h1A9F3},
    '{1, 0, 7, 0, 24'h21, 24'h3},
    '{0, 0, 7, 0, 24'h3F, 24'h0},
    '{1, 3, 1, 5, 24'h800001, 24'h3},
    '{0, 3, 0, 0, 24'hABCDEF, 24'hABCDEF}};
  always #50 i_clock = ~i_clock;
  character_shift_rotate_unit dut (.i_clock(i_clock), .i_reset(i_reset),
    .i_start(i_start), .i_instr(i_instr), .o_index_sel_valid(sel_v),
    .o_index_sel(sel), .i_index_value(i_index_value), .o_mem_rd(rd),
    .o_mem_wr(wr), .o_mem_addr(maddr), .o_mem_count_code(code),
    .i_mem_rdata(rdata), .o_mem_wdata(wdata), .o_busy(busy),
    .o_done(done), .o_illegal(illegal));
  char_mem_model mem (.i_clock(i_clock), .i_rd(rd), .i_wr(wr),
    .i_addr(maddr), .i_code(code), .i_wdata(wdata), .o_rdata(rdata));
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic complete_run;
    if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Ceiling well above the longest run of rows
  always @(posedge i_clock) begin
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic run(input row_t w, input logic [4:0] op);
    int t;
    addr = (w.x != 0) ? 15'h0028 : 15'h0020;
    for (int k = 0; k <= w.n; k++) mem.mem[addr[5:0]-6'(k)] = w.d[6*k+:6];
    @(posedge i_clock);
    i_start <= 1;
    i_instr <= {op, w.x, 1'b0, 15'h0020, w.r, w.n, w.s};
    i_index_value <= 15'h0008;
    #1 chk(24'(illegal), 24'(op != 5'h0E));
    chk(24'(sel_v), 24'(op == 5'h0E && w.x != 0));
    chk(24'(sel), 24'(w.x));
    @(posedge i_clock);
    i_start <= 0;
    // Start and read cycles already belong to the instruction time
    #1 t = 2;
    if (op != 5'h0E) chk(24'(busy), 0);
    else begin
      while (done !== 1'b1 && t < 1100) begin
        @(posedge i_clock);
        #1 t++;
      end
      chk(24'(t), 24'(81 + w.s * (18 + 36 * w.n)));
      chk(wdata, w.e);
      chk(24'(maddr), 24'(addr));
      chk(24'(code), 24'(w.n));
      @(posedge i_clock);
      #1 chk(24'(mem.mem[addr[5:0]]), 24'(w.e[5:0]));
    end
  endtask
  initial begin
    repeat (20) @(posedge i_clock);
    i_reset <= 0;
    foreach (rows[i]) run(rows[i], 5'h0E);
    run(rows[0], 5'h0F);
    run(rows[1], 5'h0E);
    // Reset in mid-instruction abandons it, then a clean run follows
    @(posedge i_clock);
    i_start <= 1;
    i_instr <= {5'h0E, 3'h0, 1'b0, 15'h0020, 1'b1, 2'h3, 3'h7};
    @(posedge i_clock);
    i_start <= 0;
    repeat (9) @(posedge i_clock);
    i_reset <= 1;
    #1 chk(24'(busy), 24'h1);
    @(posedge i_clock);
    #1 chk(24'({busy, done, wr, rd}), 24'h0);
    @(posedge i_clock);
    i_reset <= 0;
    run(rows[4], 5'h0E);
    complete_run();
  end
endmodule
`default_nettype wire
